// *** eer_event_select.sv ***
`timescale 1ns/1ps
`default_nettype none
module eer_event_select (
	input	wire logic [eer_pkg::EER_NUM_EXC-1:0]	exc_old_req,
	input	wire logic [eer_pkg::EER_NUM_EXC-1:0]	exc_young_req,
	input	wire logic				nmi_req,
	input	wire logic [3:0]			irq_req,
	input	wire logic [31:0]			sr_value,
	output	logic					evt_valid,
	output	logic [4:0]				evt_code
);
	import eer_pkg::*;

	logic [2:0]		cur;
	logic [EER_NUM_EXC-1:0]	old_ok;
	logic [EER_NUM_EXC-1:0]	yng_ok;
	logic [EER_NUM_EXC-1:0]	exc_ok;
	logic [EER_NUM_EVT-1:0]	pend;

	// Lower mode may never interrupt a higher one
	function automatic logic open(input logic [2:0] m, input logic [2:0] c);
		open = (m >= c);
	endfunction

	assign cur = sr_value[EER_SR_MODE +: 3];

	// ----------------------------------------
	// Mask gating
	// ----------------------------------------
	always_comb begin
		for (int i = 0; i < EER_NUM_EXC; i++) begin
			if (i < EER_NUM_CRIT) begin
				old_ok[i] = exc_old_req[i];
				yng_ok[i] = exc_young_req[i];
			end else begin
				old_ok[i] = exc_old_req[i] & ~sr_value[EER_SR_EM] & open(EER_M_EXC, cur);
				yng_ok[i] = exc_young_req[i] & ~sr_value[EER_SR_EM] & open(EER_M_EXC, cur);
			end
		end
	end

	// Oldest instruction first
	assign exc_ok = (|old_ok) ? old_ok : yng_ok;

	// ----------------------------------------
	// Pending vector and priority pick
	// ----------------------------------------
	always_comb begin
		pend = '0;
		pend[3:0] = exc_ok[3:0];
		pend[4] = nmi_req;
		for (int k = 0; k < 4; k++) begin
			pend[8-k] = irq_req[k] & ~sr_value[EER_SR_GM] & ~sr_value[EER_SR_I0M+k]
				& open(EER_M_IRQ_LEVEL_ZERO + 3'(k), cur);
		end
		pend[EER_NUM_EVT-1:9] = exc_ok[EER_NUM_EXC-1:4];
		evt_valid = |pend;
		evt_code = 5'h00;
		for (int i = EER_NUM_EVT - 1; i >= 0; i--) begin
			if (pend[i])
				evt_code = 5'(i);
		end
	end
endmodule
`default_nettype wire

// *** eer_event_unit.sv ***
// Operation
// - Events ranked by priority, higher preempts lower
// - Handlers spaced four bytes from vector base
// - Events 0x0a, 0x14 and 0x15 get wider spacing
// - Interrupts use 14-bit controller autovector offset
// - Handler address is base OR offset
// - All event stacking uses system stack pointer
// - Acceptance, save, switch, jump are atomic
// - Masked pending events are refused
// - Critical events ignore every mask bit
// - Accepting sets masks of equal/lower sources
// - Push status and PC; interrupts add registers
// - Exceptions set exception and global masks
// - Each exception has its own handler
// - Set mode, bank, load handler address
// - Return pops status and PC
// - Interrupt return also pops saved registers
// - Lower priority mode never interrupts higher, except critical events
// - Oldest instruction's events handled first
`timescale 1ns/1ps
`default_nettype none
module eer_event_unit (
	input	wire logic				sys_clk,
	input	wire logic				rstn,
	input	wire logic [eer_pkg::EER_NUM_EXC-1:0]	exc_old_req,
	input	wire logic [eer_pkg::EER_NUM_EXC-1:0]	exc_young_req,
	input	wire logic				nmi_pin,
	input	wire logic [3:0]			irq_req,
	input	wire logic [eer_pkg::EER_AV_W-1:0]	irq_autovec,
	input	wire logic [31:0]			ret_pc,
	input	wire logic [31:0]			bus_err_addr,
	input	wire logic				rete_req,
	input	wire logic				sreg_wr,
	input	wire logic				sreg_rd,
	input	wire logic [eer_pkg::EER_SA_W-1:0]	sreg_addr,
	input	wire logic [31:0]			sreg_wdata,
	output	logic [31:0]				sreg_rdata_ff,
	input	wire logic [31:0]			rf_rdata,
	output	logic [2:0]				rf_idx_ff,
	output	logic					rf_we_ff,
	output	logic [31:0]				rf_wdata_ff,
	output	logic					stk_req_ff,
	output	logic					stk_we_ff,
	output	logic [31:0]				stk_addr_ff,
	output	logic [31:0]				stk_wdata_ff,
	input	wire logic [31:0]			stk_rdata,
	input	wire logic				stk_ack,
	output	logic					core_hold_ff,
	output	logic					pc_load_ff,
	output	logic [31:0]				pc_value_ff,
	output	logic [31:0]				status_register_ff,
	output	logic [2:0]				bank_ff,
	output	logic					evt_ack_ff,
	output	logic [4:0]				evt_code_ff
);
	import eer_pkg::*;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_PUSH_SEL,
		ST_PUSH_REQ,
		ST_PUSH_WAIT,
		ST_POP_REQ,
		ST_POP_WAIT
	} eer_state_e;

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	eer_state_e	state_ff;
	logic		nmi_meta_ff;
	logic		nmi_sync_ff;
	logic [2:0]	ix_ff;
	logic [2:0]	last_ff;
	logic [31:0]	sp_base_ff;
	logic [31:0]	saved_pc_ff;
	logic [31:0]	saved_sr_ff;
	logic [31:0]	new_sr_ff;
	logic [31:0]	target_ff;
	logic [31:0]	event_vector_base_ff;
	logic [31:0]	system_stack_pointer_ff;
	logic [31:0]	bus_error_address_ff;
	logic [31:0]	secure_return_address_ff;
	logic [31:0]	secure_return_status_ff;
	logic		evt_valid;
	logic [4:0]	evt_code;
	logic		take_ret;
	logic		take_evt;
	logic		push_done;
	logic		pop_step;
	logic		pop_done;
	logic		cur_irq;
	logic [2:0]	ev_mode;
	logic [13:0]	ev_ofs;
	logic [31:0]	ev_sr;
	logic [31:0]	frame_bytes;

	// Register file slot of a frame word
	function automatic logic [2:0] frame_reg(input logic [2:0] ix);
		if (ix == 3'h2)
			frame_reg = 3'h5;
		else
			frame_reg = 3'h7 - ix;
	endfunction
	// Byte distance of a frame word from the base
	function automatic logic [31:0] word_ofs(input logic [2:0] n);
		word_ofs = {27'h000_0000, n, 2'b00};
	endfunction
	// NMI pin synchroniser, two stages
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			nmi_meta_ff <= 1'b0;
			nmi_sync_ff <= 1'b0;
		end else begin
			nmi_meta_ff <= nmi_pin;
			nmi_sync_ff <= nmi_meta_ff;
		end
	end
	// Priority pick among unmasked events
	eer_event_select eer_event_select_i (
		.exc_old_req	(exc_old_req),
		.exc_young_req	(exc_young_req),
		.nmi_req	(nmi_sync_ff),
		.irq_req	(irq_req),
		.sr_value	(status_register_ff),
		.evt_valid	(evt_valid),
		.evt_code	(evt_code)
	);

	// Acceptance and entry values
	always_comb begin
		take_ret = (state_ff == ST_IDLE) & rete_req;
		take_evt = (state_ff == ST_IDLE) & ~rete_req & evt_valid;
		ev_mode = eer_mode(evt_code);
		cur_irq = (bank_ff >= EER_M_IRQ_LEVEL_ZERO) & (bank_ff <= EER_M_IRQ_LEVEL_THREE);
		if (evt_code >= EER_EV_IRQ3 && evt_code <= EER_EV_IRQ0)
			ev_ofs = irq_autovec;
		else
			ev_ofs = eer_ofs(evt_code);
		ev_sr = status_register_ff;
		if (ev_mode == EER_M_EXC || ev_mode == EER_M_NMI)
			ev_sr = ev_sr | EER_MASK_ALL;
		else
			ev_sr = ev_sr | (((32'h0000_0002 << (ev_mode - EER_M_IRQ_LEVEL_ZERO)) - 32'h0000_0001) << EER_SR_I0M);
		ev_sr[EER_SR_MODE +: 3] = ev_mode;
		frame_bytes = word_ofs(last_ff) + EER_WORD;
	end

	assign push_done = (state_ff == ST_PUSH_WAIT) & stk_ack & (ix_ff == last_ff);
	assign pop_step = (state_ff == ST_POP_WAIT) & stk_ack;
	assign pop_done = pop_step & (ix_ff == 3'h0);
	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_ff <= ST_IDLE;
			ix_ff <= 3'h0;
			last_ff <= 3'h0;
		end else begin
			case (state_ff)
				ST_IDLE: begin
					if (take_ret) begin
						last_ff <= cur_irq ? EER_LAST_LONG : EER_LAST_SHORT;
						ix_ff <= cur_irq ? EER_LAST_LONG : EER_LAST_SHORT;
						state_ff <= ST_POP_REQ;
					end else if (take_evt) begin
						last_ff <= (ev_mode <= EER_M_IRQ_LEVEL_THREE) ? EER_LAST_LONG : EER_LAST_SHORT;
						ix_ff <= 3'h0;
						state_ff <= ST_PUSH_SEL;
					end
				end
				ST_PUSH_SEL: state_ff <= ST_PUSH_REQ;
				ST_PUSH_REQ: state_ff <= ST_PUSH_WAIT;
				ST_PUSH_WAIT: begin
					if (stk_ack) begin
						if (ix_ff == last_ff) begin
							state_ff <= ST_IDLE;
						end else begin
							ix_ff <= ix_ff + 3'h1;
							state_ff <= ST_PUSH_SEL;
						end
					end
				end
				ST_POP_REQ: state_ff <= ST_POP_WAIT;
				ST_POP_WAIT: begin
					if (stk_ack) begin
						if (ix_ff == 3'h0) begin
							state_ff <= ST_IDLE;
						end else begin
							ix_ff <= ix_ff - 3'h1;
							state_ff <= ST_POP_REQ;
						end
					end
				end
				default: state_ff <= ST_IDLE;
			endcase
		end
	end

	// Context captured at acceptance
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			sp_base_ff <= 32'h0000_0000;
			saved_pc_ff <= 32'h0000_0000;
			saved_sr_ff <= 32'h0000_0000;
			new_sr_ff <= 32'h0000_0000;
			target_ff <= 32'h0000_0000;
		end else if (take_ret || take_evt) begin
			sp_base_ff <= system_stack_pointer_ff;
			saved_pc_ff <= ret_pc;
			saved_sr_ff <= status_register_ff;
			new_sr_ff <= ev_sr;
			target_ff <= event_vector_base_ff | {18'h0_0000, ev_ofs};
		end
	end

	// ----------------------------------------
	// System stack port
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			stk_req_ff <= 1'b0;
			stk_we_ff <= 1'b0;
			stk_addr_ff <= 32'h0000_0000;
			stk_wdata_ff <= 32'h0000_0000;
		end else if (state_ff == ST_PUSH_REQ) begin
			stk_req_ff <= 1'b1;
			stk_we_ff <= 1'b1;
			stk_addr_ff <= sp_base_ff - word_ofs(ix_ff) - EER_WORD;
			if (ix_ff == 3'h0)
				stk_wdata_ff <= saved_pc_ff;
			else if (ix_ff == 3'h1)
				stk_wdata_ff <= saved_sr_ff;
			else
				stk_wdata_ff <= rf_rdata;
		end else if (state_ff == ST_POP_REQ) begin
			stk_req_ff <= 1'b1;
			stk_we_ff <= 1'b0;
			stk_addr_ff <= sp_base_ff + word_ofs(last_ff - ix_ff);
		end else if (stk_ack) begin
			stk_req_ff <= 1'b0;
			stk_we_ff <= 1'b0;
		end
	end
	// Register file port for the saved bank
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rf_idx_ff <= 3'h0;
			rf_we_ff <= 1'b0;
			rf_wdata_ff <= 32'h0000_0000;
		end else begin
			rf_we_ff <= 1'b0;
			if (state_ff == ST_PUSH_SEL || state_ff == ST_POP_REQ)
				rf_idx_ff <= frame_reg(ix_ff);
			if (pop_step && ix_ff >= 3'h2) begin
				rf_we_ff <= 1'b1;
				rf_wdata_ff <= stk_rdata;
			end
		end
	end

	// ----------------------------------------
	// Status register
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			status_register_ff <= EER_SR_RST;
			bank_ff <= EER_M_SUP;
		end else if (push_done) begin
			status_register_ff <= new_sr_ff;
			bank_ff <= new_sr_ff[EER_SR_MODE +: 3];
		end else if (pop_step && ix_ff == 3'h1) begin
			status_register_ff <= stk_rdata;
			bank_ff <= stk_rdata[EER_SR_MODE +: 3];
		end else if (sreg_wr && sreg_addr == EER_OFS_SR) begin
			status_register_ff <= sreg_wdata;
			bank_ff <= sreg_wdata[EER_SR_MODE +: 3];
		end
	end
	// System stack pointer moves by one frame
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			system_stack_pointer_ff <= 32'h0000_0000;
		else if (push_done)
			system_stack_pointer_ff <= sp_base_ff - frame_bytes;
		else if (pop_done)
			system_stack_pointer_ff <= sp_base_ff + frame_bytes;
		else if (sreg_wr && sreg_addr == EER_OFS_SSP)
			system_stack_pointer_ff <= sreg_wdata;
	end
	// Stall and jump to the core
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			core_hold_ff <= 1'b0;
			pc_load_ff <= 1'b0;
			pc_value_ff <= 32'h0000_0000;
		end else begin
			core_hold_ff <= take_ret | take_evt | ((state_ff != ST_IDLE) & ~push_done & ~pop_done);
			pc_load_ff <= push_done | pop_done;
			if (push_done)
				pc_value_ff <= target_ff;
			else if (pop_done)
				pc_value_ff <= stk_rdata;
		end
	end

	// Acceptance strobe back to the sources
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			evt_ack_ff <= 1'b0;
			evt_code_ff <= 5'h00;
		end else begin
			evt_ack_ff <= take_evt;
			if (take_evt)
				evt_code_ff <= evt_code;
		end
	end
	// Other system registers, software owned
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			event_vector_base_ff <= 32'h0000_0000;
			secure_return_address_ff <= 32'h0000_0000;
			secure_return_status_ff <= 32'h0000_0000;
		end else if (sreg_wr) begin
			if (sreg_addr == EER_OFS_EVENT_VECTOR_BASE)
				event_vector_base_ff <= sreg_wdata;
			if (sreg_addr == EER_OFS_SRA)
				secure_return_address_ff <= sreg_wdata;
			if (sreg_addr == EER_OFS_SRS)
				secure_return_status_ff <= sreg_wdata;
		end
	end

	// Bus error address, capture beats software write
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			bus_error_address_ff <= 32'h0000_0000;
		else if (take_evt && (evt_code == EER_EV_BED || evt_code == EER_EV_BEI))
			bus_error_address_ff <= bus_err_addr;
		else if (sreg_wr && sreg_addr == EER_OFS_BUS_ERROR_ADDRESS)
			bus_error_address_ff <= sreg_wdata;
	end

	// ----------------------------------------
	// Register read port
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			sreg_rdata_ff <= 32'h0000_0000;
		end else if (sreg_rd) begin
			case (sreg_addr)
				EER_OFS_SR: sreg_rdata_ff <= status_register_ff;
				EER_OFS_EVENT_VECTOR_BASE: sreg_rdata_ff <= event_vector_base_ff;
				EER_OFS_BUS_ERROR_ADDRESS: sreg_rdata_ff <= bus_error_address_ff;
				EER_OFS_SRA: sreg_rdata_ff <= secure_return_address_ff;
				EER_OFS_SRS: sreg_rdata_ff <= secure_return_status_ff;
				EER_OFS_SSP: sreg_rdata_ff <= system_stack_pointer_ff;
				default: sreg_rdata_ff <= 32'h0000_0000;
			endcase
		end
	end
endmodule
`default_nettype wire

// *** eer_event_unit_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module eer_event_unit_props (
	input	wire logic				sys_clk,
	input	wire logic				rstn,
	input	wire logic [eer_pkg::EER_NUM_EXC-1:0]	exc_old_req,
	input	wire logic				rete_req,
	input	wire logic				sreg_rd,
	input	wire logic [eer_pkg::EER_SA_W-1:0]	sreg_addr,
	input	wire logic [31:0]			sreg_rdata_ff,
	input	wire logic				rf_we_ff,
	input	wire logic				stk_req_ff,
	input	wire logic				stk_we_ff,
	input	wire logic [31:0]			stk_addr_ff,
	input	wire logic				stk_ack,
	input	wire logic				core_hold_ff,
	input	wire logic				pc_load_ff,
	input	wire logic [31:0]			status_register_ff,
	input	wire logic [2:0]			bank_ff,
	input	wire logic				evt_ack_ff,
	input	wire logic [4:0]			evt_code_ff
);
	import eer_pkg::*;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	logic		in_ent_ff;
	logic [4:0]	ent_code_ff;
	wire logic	irq_ent = in_ent_ff && ent_code_ff >= EER_EV_IRQ3 && ent_code_ff <= EER_EV_IRQ0;
	wire logic [2:0] mode = status_register_ff[EER_SR_MODE+:3];
	// Event being entered, kept until its handler jump
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			in_ent_ff <= 1'b0;
			ent_code_ff <= 5'h00;
		end else if (evt_ack_ff) begin
			in_ent_ff <= 1'b1;
			ent_code_ff <= evt_code_ff;
		end else if (pc_load_ff) begin
			in_ent_ff <= 1'b0;
		end
	end
	sequence s_busy;
		core_hold_ff && !evt_ack_ff;
	endsequence
	sequence s_jump;
		pc_load_ff && in_ent_ff;
	endsequence
	sequence s_idle_crit;
		!core_hold_ff && !evt_ack_ff && !rete_req && (|exc_old_req[3:0]) && mode < EER_M_EXC;
	endsequence
	a_ack_one_pulse: assert property (evt_ack_ff |-> core_hold_ff ##1 s_busy)
		else $error("accept pulse without stall");
	a_stack_req_held: assert property (stk_req_ff && !stk_ack |=> stk_req_ff && $stable(stk_addr_ff) && $stable(stk_we_ff))
		else $error("stack request changed before ack");
	a_stack_word_align: assert property (stk_req_ff |-> stk_addr_ff[1:0] == 2'b00)
		else $error("stack address not word aligned");
	a_bank_follows_mode: assert property (bank_ff == mode)
		else $error("bank differs from mode");
	a_crit_unmasked: assert property (s_idle_crit |-> ##[1:2] evt_ack_ff)
		else $error("critical event not accepted");
	a_irq_mask_clear: assert property (evt_ack_ff && evt_code_ff >= EER_EV_IRQ3 && evt_code_ff <= EER_EV_IRQ0
		|-> !status_register_ff[EER_SR_GM] && !status_register_ff[EER_SR_I0M + int'(EER_EV_IRQ0 - evt_code_ff)]
		&& mode <= EER_M_IRQ_LEVEL_ZERO + 3'(EER_EV_IRQ0 - evt_code_ff))
		else $error("masked interrupt accepted");
	a_exc_all_masks: assert property ((s_jump and !irq_ent) |-> status_register_ff[21:16] == 6'h3f
		&& mode == (ent_code_ff == EER_EV_NMI ? EER_M_NMI : EER_M_EXC))
		else $error("exception entry masks or mode wrong");
	a_irq_level_masks: assert property ((s_jump and irq_ent) |-> mode == EER_M_IRQ_LEVEL_ZERO + 3'(EER_EV_IRQ0 - ent_code_ff)
		&& status_register_ff[20:17] == (4'hf >> (ent_code_ff - EER_EV_IRQ3)))
		else $error("interrupt entry masks or mode wrong");
	a_restore_in_return: assert property (rf_we_ff |-> core_hold_ff && !in_ent_ff && !stk_we_ff)
		else $error("register restore outside return");
	a_unmapped_zero: assert property (sreg_rd && sreg_addr == 10'h008 |=> sreg_rdata_ff == 32'h0000_0000)
		else $error("unmapped read not zero");
endmodule
bind eer_event_unit eer_event_unit_props eer_event_unit_props_i (.sys_clk(sys_clk), .rstn(rstn),
	.exc_old_req(exc_old_req), .rete_req(rete_req), .sreg_rd(sreg_rd), .sreg_addr(sreg_addr),
	.sreg_rdata_ff(sreg_rdata_ff), .rf_we_ff(rf_we_ff), .stk_req_ff(stk_req_ff), .stk_we_ff(stk_we_ff),
	.stk_addr_ff(stk_addr_ff), .stk_ack(stk_ack), .core_hold_ff(core_hold_ff), .pc_load_ff(pc_load_ff),
	.status_register_ff(status_register_ff), .bank_ff(bank_ff), .evt_ack_ff(evt_ack_ff), .evt_code_ff(evt_code_ff));
`default_nettype wire

// *** eer_event_unit_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module eer_event_unit_tb;
	import eer_pkg::*;
	logic		sys_clk = 1'b0, rstn = 1'b0, nmi_pin = 1'b0, rete_req = 1'b0;
	logic		sreg_wr = 1'b0, sreg_rd = 1'b0, stk_ack = 1'b0, stk_wt = 1'b0;
	logic [19:0]	exc_old_req = '0, exc_young_req = '0;
	logic [9:0]	sreg_addr = 10'h000;
	logic [31:0]	ret_pc = '0, bus_err_addr = '0, sreg_wdata = '0, stk_rdata = '0;
	logic [3:0]	lvl_set = 4'h0, irq_req;
	logic [13:0]	irq_autovec;
	logic [31:0]	sreg_rdata_ff, rf_wdata_ff, stk_addr_ff, stk_wdata_ff, pc_value_ff, status_register_ff;
	logic [2:0]	rf_idx_ff, bank_ff;
	logic [4:0]	evt_code_ff;
	logic		rf_we_ff, stk_req_ff, stk_we_ff, core_hold_ff, pc_load_ff, evt_ack_ff;
	wire logic [31:0] rf_rdata = 32'h0000_0a00 | {29'h0000_0000, rf_idx_ff};
	logic [31:0]	mem [0:255];
	int		errors = 0, n_compared = 0, n_ack = 0, n_rf = 0, k;
	always #10 sys_clk = ~sys_clk;
	eer_event_unit eer_event_unit_i (.sys_clk(sys_clk), .rstn(rstn), .exc_old_req(exc_old_req),
		.exc_young_req(exc_young_req), .nmi_pin(nmi_pin), .irq_req(irq_req), .irq_autovec(irq_autovec),
		.ret_pc(ret_pc), .bus_err_addr(bus_err_addr), .rete_req(rete_req), .sreg_wr(sreg_wr), .sreg_rd(sreg_rd),
		.sreg_addr(sreg_addr), .sreg_wdata(sreg_wdata), .sreg_rdata_ff(sreg_rdata_ff), .rf_rdata(rf_rdata),
		.rf_idx_ff(rf_idx_ff), .rf_we_ff(rf_we_ff), .rf_wdata_ff(rf_wdata_ff), .stk_req_ff(stk_req_ff),
		.stk_we_ff(stk_we_ff), .stk_addr_ff(stk_addr_ff), .stk_wdata_ff(stk_wdata_ff), .stk_rdata(stk_rdata),
		.stk_ack(stk_ack), .core_hold_ff(core_hold_ff), .pc_load_ff(pc_load_ff), .pc_value_ff(pc_value_ff),
		.status_register_ff(status_register_ff), .bank_ff(bank_ff), .evt_ack_ff(evt_ack_ff), .evt_code_ff(evt_code_ff));
	eer_intc_model eer_intc_model_i (.sys_clk(sys_clk), .rstn(rstn), .lvl_set(lvl_set), .evt_ack_ff(evt_ack_ff),
		.evt_code_ff(evt_code_ff), .irq_req(irq_req), .irq_autovec(irq_autovec));
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (exp !== got) begin
			errors++;
			$display("unexpected %s: expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wrap_up();
		if (errors == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Stack memory: one wait state, one ack per request, stale read data inverted
	always @(negedge sys_clk) begin
		stk_wt <= stk_req_ff && !stk_ack && !stk_wt;
		stk_ack <= stk_req_ff && stk_wt;
		if (stk_req_ff && stk_wt && stk_we_ff)
			mem[stk_addr_ff[9:2]] <= stk_wdata_ff;
		stk_rdata <= (stk_req_ff && stk_wt && !stk_we_ff) ? mem[stk_addr_ff[9:2]] : ~stk_rdata;
	end
	// Accept count and restored register values
	always @(negedge sys_clk) begin
		if (evt_ack_ff === 1'b1)
			n_ack++;
		if (rf_we_ff === 1'b1) begin
			n_rf++;
			chk("rf_wdata_ff", 32'h0000_0a00 | {29'h0000_0000, rf_idx_ff}, rf_wdata_ff);
		end
	end
	task automatic wr_reg(input logic [9:0] a, input logic [31:0] d);
		@(negedge sys_clk);
		sreg_wr = 1'b1;
		sreg_addr = a;
		sreg_wdata = d;
		@(negedge sys_clk);
		sreg_wr = 1'b0;
	endtask
	task automatic rd_chk(input logic [9:0] a, input logic [31:0] exp);
		@(negedge sys_clk);
		sreg_rd = 1'b1;
		sreg_addr = a;
		@(negedge sys_clk);
		sreg_rd = 1'b0;
		chk("sreg_rdata_ff", exp, sreg_rdata_ff);
	endtask
	task automatic wt_ack(input logic [4:0] code);
		for (k = 0; k < 60 && evt_ack_ff !== 1'b1; k++) @(negedge sys_clk);
		chk("evt_ack_ff", 1'b1, evt_ack_ff);
		chk("evt_code_ff", code, evt_code_ff);
	endtask
	task automatic wt_pc(input logic [31:0] pc, input logic [31:0] st);
		for (k = 0; k < 200 && pc_load_ff !== 1'b1; k++) @(negedge sys_clk);
		chk("pc_load_ff", 1'b1, pc_load_ff);
		chk("pc_value_ff", pc, pc_value_ff);
		chk("status_register_ff", st, status_register_ff);
		chk("bank_ff", st[24:22], bank_ff);
	endtask
	task automatic leave(input logic [31:0] pc, input logic [31:0] st);
		@(negedge sys_clk);
		rete_req = 1'b1;
		@(negedge sys_clk);
		rete_req = 1'b0;
		wt_pc(pc, st);
	endtask
	task automatic t_regs();
		rd_chk(EER_OFS_SR, EER_SR_RST);
		chk("bank_ff", 3'h1, bank_ff);
		rd_chk(10'h008, 32'h0000_0000);
		wr_reg(EER_OFS_SRA, 32'h5a5a_0001);
		rd_chk(EER_OFS_SRA, 32'h5a5a_0001);
		wr_reg(EER_OFS_SRS, 32'h0a5a_0002);
		rd_chk(EER_OFS_SRS, 32'h0a5a_0002);
		wr_reg(EER_OFS_EVENT_VECTOR_BASE, 32'h0000_4008);
		wr_reg(EER_OFS_SSP, 32'h0000_0200);
		rd_chk(EER_OFS_SSP, 32'h0000_0200);
	endtask
	// Critical events and NMI taken with global and exception masks set
	task automatic t_crit();
		for (int i = 0; i < 5; i++) begin
			@(negedge sys_clk);
			ret_pc = {28'h000_0111, 4'(i)};
			bus_err_addr = {28'h123_4567, 4'(i)};
			if (i < 4)
				exc_old_req[i] = 1'b1;
			else
				nmi_pin = 1'b1;
			wt_ack(5'(i));
			exc_old_req = '0;
			nmi_pin = 1'b0;
			wt_pc(32'h0000_4008 | {26'h000_0000, 4'(i), 2'b00}, i == 4 ? 32'h01ff_0000 : 32'h01bf_0000);
			chk("stack pc", ret_pc, mem[8'h7f]);
			chk("stack status", EER_SR_RST, mem[8'h7e]);
			rd_chk(EER_OFS_SSP, 32'h0000_01f8);
			leave(ret_pc, EER_SR_RST);
		end
		rd_chk(EER_OFS_SSP, 32'h0000_0200);
		rd_chk(EER_OFS_BUS_ERROR_ADDRESS, 32'h1234_5673);
	endtask
	// Two levels pending, masked first, then taken in turn
	task automatic t_irq();
		k = n_ack;
		@(negedge sys_clk);
		lvl_set = 4'b0011;
		@(negedge sys_clk);
		lvl_set = 4'h0;
		repeat (20) @(negedge sys_clk);
		chk("accept count", k, n_ack);
		ret_pc = 32'h0000_2220;
		wr_reg(EER_OFS_SR, 32'h0040_0000);
		wt_ack(5'h07);
		wt_pc(32'h0000_640c, 32'h00c6_0000);
		chk("stack pc", 32'h0000_2220, mem[8'h7f]);
		chk("stack status", 32'h0040_0000, mem[8'h7e]);
		for (int i = 0; i < 6; i++)
			chk("stack reg", 32'h0000_0a05 - i, mem[8'h7d - i]);
		rd_chk(EER_OFS_SSP, 32'h0000_01e0);
		k = n_ack;
		repeat (10) @(negedge sys_clk);
		chk("accept count", k, n_ack);
		n_rf = 0;
		ret_pc = 32'h0000_3330;
		leave(32'h0000_2220, 32'h0040_0000);
		chk("restores", 6, n_rf);
		wt_ack(5'h08);
		wt_pc(32'h0000_600c, 32'h0082_0000);
		leave(32'h0000_3330, 32'h0040_0000);
		rd_chk(EER_OFS_SSP, 32'h0000_0200);
	endtask
	// Oldest instruction first; wide-spaced handler offset
	task automatic t_order();
		@(negedge sys_clk);
		ret_pc = 32'h0000_4440;
		exc_old_req[5] = 1'b1;
		exc_young_req[0] = 1'b1;
		wt_ack(5'h0a);
		exc_old_req = '0;
		exc_young_req = '0;
		wt_pc(32'h0000_4058, 32'h01bf_0000);
		leave(32'h0000_4440, 32'h0040_0000);
	endtask
	initial begin
		repeat (12) @(posedge sys_clk);
		@(negedge sys_clk);
		rstn = 1'b1;
		t_regs();
		t_crit();
		t_irq();
		t_order();
		wrap_up();
	end
	// Watchdog
	initial begin
		#200000;
		errors++;
		wrap_up();
	end
endmodule
`default_nettype wire

// *** eer_intc_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module eer_intc_model (
	input	wire logic		sys_clk,
	input	wire logic		rstn,
	input	wire logic [3:0]	lvl_set,
	input	wire logic		evt_ack_ff,
	input	wire logic [4:0]	evt_code_ff,
	output	logic [3:0]		irq_req,
	output	logic [13:0]		irq_autovec
);
	logic [3:0]	pend_ff;
	logic [1:0]	win;
	wire logic	irq_ack = evt_ack_ff && evt_code_ff >= 5'h05 && evt_code_ff <= 5'h08;
	assign win = pend_ff[3] ? 2'd3 : pend_ff[2] ? 2'd2 : pend_ff[1] ? 2'd1 : 2'd0;
	initial begin
		irq_req = 4'h0;
		irq_autovec = 14'h0000;
	end
	// Level stays pending until the core accepts it
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			pend_ff <= 4'h0;
		else
			pend_ff <= (pend_ff | lvl_set) & ~(irq_ack ? 4'h1 << (5'h08 - evt_code_ff) : 4'h0);
	end
	// Highest level wins; its 14-bit offset shown, stale offset inverted
	always @(negedge sys_clk) begin
		irq_req <= pend_ff;
		irq_autovec <= (|pend_ff) ? {2'b10, win, 10'h00c} : ~irq_autovec;
	end
endmodule
`default_nettype wire

// *** eer_pkg.sv ***
`default_nettype none
package eer_pkg;
	// ----------------------------------------
	// Sizes
	// ----------------------------------------
	localparam int EER_NUM_EXC = 20;
	localparam int EER_NUM_EVT = 25;
	localparam int EER_NUM_CRIT = 4;
	localparam int EER_AV_W = 14;
	localparam int EER_SA_W = 10;
	// ----------------------------------------
	// System register offsets
	// ----------------------------------------
	localparam logic [9:0] EER_OFS_SR = 10'h000;
	localparam logic [9:0] EER_OFS_EVENT_VECTOR_BASE = 10'h004;
	localparam logic [9:0] EER_OFS_BUS_ERROR_ADDRESS = 10'h13c;
	localparam logic [9:0] EER_OFS_SRA = 10'h1b8;
	localparam logic [9:0] EER_OFS_SRS = 10'h1bc;
	localparam logic [9:0] EER_OFS_SSP = 10'h3fc;
	// ----------------------------------------
	// Status register layout
	// ----------------------------------------
	localparam int EER_SR_GM = 16;
	localparam int EER_SR_I0M = 17;
	localparam int EER_SR_EM = 21;
	localparam int EER_SR_MODE = 22;
	localparam logic [31:0] EER_SR_RST = 32'h0061_0000;
	localparam logic [31:0] EER_MASK_ALL = 32'h003f_0000;
	localparam logic [2:0] EER_M_SUP = 3'h1;
	localparam logic [2:0] EER_M_IRQ_LEVEL_ZERO = 3'h2;
	localparam logic [2:0] EER_M_IRQ_LEVEL_THREE = 3'h5;
	localparam logic [2:0] EER_M_EXC = 3'h6;
	localparam logic [2:0] EER_M_NMI = 3'h7;
	// ----------------------------------------
	// Event codes, in priority order
	// ----------------------------------------
	localparam logic [4:0] EER_EV_NMI = 5'h04;
	localparam logic [4:0] EER_EV_IRQ3 = 5'h05;
	localparam logic [4:0] EER_EV_IRQ0 = 5'h08;
	localparam logic [4:0] EER_EV_BED = 5'h02;
	localparam logic [4:0] EER_EV_BEI = 5'h03;
	localparam logic [2:0] EER_LAST_SHORT = 3'h1;
	localparam logic [2:0] EER_LAST_LONG = 3'h7;
	localparam logic [31:0] EER_WORD = 32'h0000_0004;

	// Handler offset of a fixed-vector event
	function automatic logic [13:0] eer_ofs(input logic [4:0] c);
		case (c)
			5'h00: eer_ofs = 14'h0000;
			5'h01: eer_ofs = 14'h0004;
			5'h02: eer_ofs = 14'h0008;
			5'h03: eer_ofs = 14'h000c;
			5'h04: eer_ofs = 14'h0010;
			5'h09: eer_ofs = 14'h0014;
			5'h0a: eer_ofs = 14'h0050;
			5'h0b: eer_ofs = 14'h0018;
			5'h0c: eer_ofs = 14'h001c;
			5'h0d: eer_ofs = 14'h0020;
			5'h0e: eer_ofs = 14'h0024;
			5'h0f: eer_ofs = 14'h0028;
			5'h10: eer_ofs = 14'h002c;
			5'h11: eer_ofs = 14'h0030;
			5'h12: eer_ofs = 14'h0034;
			5'h13: eer_ofs = 14'h0038;
			5'h14: eer_ofs = 14'h0060;
			5'h15: eer_ofs = 14'h0070;
			5'h16: eer_ofs = 14'h003c;
			5'h17: eer_ofs = 14'h0040;
			5'h18: eer_ofs = 14'h0044;
			default: eer_ofs = 14'h0000;
		endcase
	endfunction

	// Execution mode entered by an event
	function automatic logic [2:0] eer_mode(input logic [4:0] c);
		logic [4:0] d;
		d = EER_EV_IRQ0 - c;
		if (c == EER_EV_NMI)
			eer_mode = EER_M_NMI;
		else if (c >= EER_EV_IRQ3 && c <= EER_EV_IRQ0)
			eer_mode = EER_M_IRQ_LEVEL_ZERO + d[2:0];
		else
			eer_mode = EER_M_EXC;
	endfunction
endpackage
`default_nettype wire
